// >>> rtl/cfg_defines.svh
// Timing counts, field positions and reset values of the configuration output block
`ifndef CFG_DEFINES_SVH
`define CFG_DEFINES_SVH

// Stored word layout: run flag, repeat count, data byte
`define CFG_WORD_W 16
`define CFG_RUN_FLAG_BIT 15
`define CFG_REP_MSB 14
`define CFG_REP_LSB 8
`define CFG_DATA_MSB 7
`define CFG_DATA_LSB 0

// System clock period in picoseconds (250 MHz)
`define CFG_SYS_CLK_PERIOD_PS 4000

// Highest configuration clock rate in kHz (33 MHz)
`define CFG_CLK_MAX_KHZ 33000

// Least half period of the generated clock, rounded up to system cycles
`define CFG_CLK_HALF_PS (1000000000 / (2 * `CFG_CLK_MAX_KHZ))
`define CFG_CLK_HALF_CYCLES \
	((`CFG_CLK_HALF_PS + `CFG_SYS_CLK_PERIOD_PS - 1) / `CFG_SYS_CLK_PERIOD_PS)

// Least low time of the program pulse to the programmable device
`define CFG_PROG_PULSE_NS 500
`define CFG_PROG_PULSE_CYCLES \
	((`CFG_PROG_PULSE_NS * 1000 + `CFG_SYS_CLK_PERIOD_PS - 1) / `CFG_SYS_CLK_PERIOD_PS)

// Revision held by the internal control bits after reset
`define CFG_REV_RESET 2'h0

`endif

// >>> rtl/cfg_pkg.sv
// Types shared by the configuration output block
package cfg_pkg;

	// Streaming state of the link side, one-hot
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_PRIME = 3'b010,
		ST_RUN = 3'b100
	} link_state_t;

endpackage

// >>> rtl/cfg_bitstream_store.sv
// Bitstream memory: written from the system clock, read with a registered output
`timescale 1ns/10ps
`default_nettype none

module cfg_bitstream_store #(
	parameter int WIDTH = 16,
	parameter int ADDR_W = 10
) (
	input wire logic wr_clk,
	input wire logic wr_en,
	input wire logic [ADDR_W-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic rd_clk,
	input wire logic [ADDR_W-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);

	// Storage array
	logic [WIDTH-1:0] mem [0:(1<<ADDR_W)-1];

	////////////////////////////////////////////////////////////////////////////////
	// Write port on the system clock
	always_ff @(posedge wr_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read port on the link clock; data leaves from a register
	always_ff @(posedge rd_clk) begin
		rd_data <= mem[rd_addr];
	end

endmodule // cfg_bitstream_store

`default_nettype wire

// >>> rtl/cfg_decompressor.sv
// Run-length expander between the bitstream memory and the output stage
`timescale 1ns/10ps
`default_nettype none

`include "cfg_defines.svh"

module cfg_decompressor (
	input wire logic clk,
	input wire logic rst,
	input wire logic restart,
	input wire logic compress_en,
	input wire logic [`CFG_WORD_W-1:0] in_word,
	output logic in_pop,
	input wire logic take,
	output logic [7:0] out_byte,
	output logic out_valid
);

	// Current stored word
	logic [`CFG_WORD_W-1:0] word_reg;
	// Repeats still owed for the current byte
	logic [6:0] rep_reg;
	// A word is loaded
	logic have_reg;

	// Last repeat of the current byte is being taken
	wire last_take = have_reg & take & (rep_reg == 7'h00);
	// Repeat count of the incoming word, zero when expansion is off
	wire [6:0] in_rep = (compress_en & in_word[`CFG_RUN_FLAG_BIT]) ?
		in_word[`CFG_REP_MSB:`CFG_REP_LSB] : 7'h00;

	assign in_pop = ~restart & (~have_reg | last_take);
	assign out_byte = word_reg[`CFG_DATA_MSB:`CFG_DATA_LSB];
	assign out_valid = have_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Load a new word when empty or spent, else count repeats down
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			word_reg <= 16'h0000;
			rep_reg <= 7'h00;
			have_reg <= 1'b0;
		end else if (restart) begin
			// Drop the held word; the memory is re-pointed meanwhile
			have_reg <= 1'b0;
		end else if (in_pop) begin
			word_reg <= in_word;
			rep_reg <= in_rep;
			have_reg <= 1'b1;
		end else if (have_reg & take) begin
			rep_reg <= rep_reg - 7'h01;
		end
	end

endmodule // cfg_decompressor

`default_nettype wire

// >>> rtl/config_prom_bitstream_output.sv
// Configuration memory output stage: serial and byte-wide bitstream streaming
`timescale 1ns/10ps
`default_nettype none

`include "cfg_defines.svh"

module config_prom_bitstream_output #(
	parameter int ADDR_W = 10,
	parameter int REV_W = 2
) (
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic CONFIG_CLOCK,
	input wire logic RECONFIG_REQUEST_N,
	input wire logic CHIP_ENABLE_N,
	input wire logic OUTPUT_ENABLE_N,
	input wire logic BUSY,
	input wire logic PARALLEL_MODE,
	input wire logic COMPRESS_EN,
	input wire logic [REV_W-1:0] REV_SEL,
	input wire logic REV_SOURCE_INTERNAL,
	input wire logic REV_WR,
	input wire logic [REV_W-1:0] REV_WR_VALUE,
	input wire logic CLOCK_SOURCE_EN,
	input wire logic START_CONFIG,
	input wire logic PROG_WR_EN,
	input wire logic [ADDR_W-1:0] PROG_WR_ADDR,
	input wire logic [`CFG_WORD_W-1:0] PROG_WR_DATA,
	output logic SERIAL_OUT_BIT,
	output logic SERIAL_OUT_OE_N,
	output logic [7:0] PARALLEL_OUT_BYTE,
	output logic PARALLEL_OUT_OE_N,
	output logic CONFIG_CLOCK_OUT,
	output logic CONFIG_CLOCK_OUT_OE_N,
	output logic PROGRAM_N_OUT,
	output logic PROGRAM_N_OE_N,
	output logic STREAM_ACTIVE,
	output logic [REV_W-1:0] REV_INTERNAL
);

	// Generated clock half period in system cycles
	localparam logic [3:0] CLK_HALF = 4'(`CFG_CLK_HALF_CYCLES);
	// Program pulse length in system cycles
	localparam logic [7:0] PROG_LEN = 8'(`CFG_PROG_PULSE_CYCLES);

	// Start address of a revision: revisions split the memory evenly
	function automatic logic [ADDR_W-1:0] rev_base(input logic [REV_W-1:0] rev);
		rev_base = {rev, {(ADDR_W-REV_W){1'b0}}};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// System domain: internal revision bits

	// Internal revision control bits
	logic [REV_W-1:0] rev_int_reg;

	// Software-style write of the internal revision bits
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			rev_int_reg <= `CFG_REV_RESET;
		end else if (REV_WR) begin
			rev_int_reg <= REV_WR_VALUE;
		end
	end

	assign REV_INTERNAL = rev_int_reg;

	////////////////////////////////////////////////////////////////////////////////
	// System domain: configuration clock generator

	// Half period counter
	logic [3:0] div_cnt_reg;
	// Generated clock level
	logic clk_out_reg;

	// Toggle every CLK_HALF cycles so the rate stays at or under the ceiling
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			div_cnt_reg <= 4'h0;
			clk_out_reg <= 1'b0;
		end else if (!CLOCK_SOURCE_EN) begin
			// Parked low while another party makes the clock
			div_cnt_reg <= 4'h0;
			clk_out_reg <= 1'b0;
		end else if (div_cnt_reg == CLK_HALF - 4'h1) begin
			div_cnt_reg <= 4'h0;
			clk_out_reg <= ~clk_out_reg;
		end else begin
			div_cnt_reg <= div_cnt_reg + 4'h1;
		end
	end

	assign CONFIG_CLOCK_OUT = clk_out_reg;
	// Driven only when this memory is the clock source
	assign CONFIG_CLOCK_OUT_OE_N = ~CLOCK_SOURCE_EN;

	////////////////////////////////////////////////////////////////////////////////
	// System domain: start of a standard configuration

	// Remaining low time of the program pulse
	logic [7:0] prog_cnt_reg;
	// Open-drain pull is active
	logic prog_low_reg;

	// A start command pulls the program line low for the full pulse length
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			prog_cnt_reg <= 8'h00;
			prog_low_reg <= 1'b0;
		end else if (START_CONFIG && !prog_low_reg) begin
			prog_cnt_reg <= PROG_LEN - 8'h01;
			prog_low_reg <= 1'b1;
		end else if (prog_low_reg) begin
			if (prog_cnt_reg == 8'h00) begin
				prog_low_reg <= 1'b0;
			end else begin
				prog_cnt_reg <= prog_cnt_reg - 8'h01;
			end
		end
	end

	// Open drain: the line only ever goes low
	assign PROGRAM_N_OUT = 1'b0;
	assign PROGRAM_N_OE_N = ~prog_low_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Link domain: reset release synchronised to the link clock

	// Reset synchroniser stages
	logic lrst_meta_reg;
	logic lrst_reg;

	// Asserts at once, releases on the second link edge
	always_ff @(posedge CONFIG_CLOCK or posedge RST) begin
		if (RST) begin
			lrst_meta_reg <= 1'b1;
			lrst_reg <= 1'b1;
		end else begin
			lrst_meta_reg <= 1'b0;
			lrst_reg <= lrst_meta_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Link domain: pin and cross-domain synchronisers

	// First and second stages of each level
	logic [6:0] pin_meta_reg;
	logic [6:0] pin_reg;
	logic [2*REV_W-1:0] rev_meta_reg;
	logic [2*REV_W-1:0] rev_reg;

	// Two flops ahead of any logic that reads the pins or system-side bits
	always_ff @(posedge CONFIG_CLOCK or posedge lrst_reg) begin
		if (lrst_reg) begin
			pin_meta_reg <= 7'h00;
			pin_reg <= 7'h00;
			rev_meta_reg <= '0;
			rev_reg <= '0;
		end else begin
			pin_meta_reg <= {RECONFIG_REQUEST_N, ~CHIP_ENABLE_N, ~OUTPUT_ENABLE_N,
				BUSY, PARALLEL_MODE, COMPRESS_EN, REV_SOURCE_INTERNAL};
			pin_reg <= pin_meta_reg;
			rev_meta_reg <= {rev_int_reg, REV_SEL};
			rev_reg <= rev_meta_reg;
		end
	end

	// Named views of the synchronised levels
	wire released = pin_reg[6];
	wire enabled = pin_reg[5] & pin_reg[4];
	wire busy_s = pin_reg[3];
	wire parallel_s = pin_reg[2];
	wire compress_s = pin_reg[1];
	wire rev_internal_s = pin_reg[0];
	// Revision from internal bits or the selection pins
	wire [REV_W-1:0] rev_active = rev_internal_s ? rev_reg[2*REV_W-1:REV_W] :
		rev_reg[REV_W-1:0];

	////////////////////////////////////////////////////////////////////////////////
	// Link domain: streaming control

	// Streaming state
	cfg_pkg::link_state_t state_reg;
	cfg_pkg::link_state_t state_next;
	// Memory read pointer
	logic [ADDR_W-1:0] addr_reg;
	// Serial shift register and bit position
	logic [7:0] shift_reg;
	logic [2:0] bit_cnt_reg;
	// Byte presented on the parallel pins
	logic [7:0] byte_reg;
	// Memory word and expander handshake
	logic [`CFG_WORD_W-1:0] mem_word;
	logic dec_pop;
	logic [7:0] dec_byte;
	logic dec_valid;

	// Pointer held at the revision start while idle
	wire idle = (state_reg == cfg_pkg::ST_IDLE);
	wire prime = (state_reg == cfg_pkg::ST_PRIME);
	wire run = (state_reg == cfg_pkg::ST_RUN);
	// Serial advances on every edge while enabled
	wire ser_step = run & enabled & ~parallel_s;
	// Byte-wide advances only while busy is low
	wire par_step = run & enabled & parallel_s & ~busy_s;
	// Load the output stage from the expander
	wire load_out = (prime & dec_valid) |
		(ser_step & (bit_cnt_reg == 3'h7)) | par_step;
	// Read address runs one ahead so memory data is ready when popped
	wire [ADDR_W-1:0] addr_next = idle ? rev_base(rev_active) :
		(dec_pop ? addr_reg + {{(ADDR_W-1){1'b0}}, 1'b1} : addr_reg);

	// Next state: released request primes the stage, a low request restarts
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			cfg_pkg::ST_IDLE: begin
				// Wait for the reconfiguration request to release
				if (released) begin
					state_next = cfg_pkg::ST_PRIME;
				end
			end
			cfg_pkg::ST_PRIME: begin
				// First data lands in the output stage
				if (!released) begin
					state_next = cfg_pkg::ST_IDLE;
				end else if (dec_valid) begin
					state_next = cfg_pkg::ST_RUN;
				end
			end
			cfg_pkg::ST_RUN: begin
				// Streams until restarted; the device decides when to stop
				if (!released) begin
					state_next = cfg_pkg::ST_IDLE;
				end
			end
			default: begin
				state_next = cfg_pkg::ST_IDLE;
			end
		endcase
	end

	// State and pointer registers
	always_ff @(posedge CONFIG_CLOCK or posedge lrst_reg) begin
		if (lrst_reg) begin
			state_reg <= cfg_pkg::ST_IDLE;
			addr_reg <= '0;
		end else begin
			state_reg <= state_next;
			addr_reg <= addr_next;
		end
	end

	// Output stage: first data preloaded, new data after each rising edge with ser_step or par_step
	always_ff @(posedge CONFIG_CLOCK or posedge lrst_reg) begin
		if (lrst_reg) begin
			shift_reg <= 8'h00;
			bit_cnt_reg <= 3'h0;
			byte_reg <= 8'h00;
		end else if (idle) begin
			bit_cnt_reg <= 3'h0;
		end else if (load_out) begin
			shift_reg <= dec_byte;
			byte_reg <= dec_byte;
			bit_cnt_reg <= 3'h0;
		end else if (ser_step) begin
			shift_reg <= {shift_reg[6:0], 1'b0};
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Link domain: memory and expander

	// Bitstream store; loaded over the programming port
	cfg_bitstream_store #(
		.WIDTH(`CFG_WORD_W),
		.ADDR_W(ADDR_W)
	) u_store (
		.wr_clk(SYS_CLK),
		.wr_en(PROG_WR_EN),
		.wr_addr(PROG_WR_ADDR),
		.wr_data(PROG_WR_DATA),
		.rd_clk(CONFIG_CLOCK),
		.rd_addr(addr_next),
		.rd_data(mem_word)
	);

	// Run-length expander feeding the output stage
	cfg_decompressor u_expand (
		.clk(CONFIG_CLOCK),
		.rst(lrst_reg),
		.restart(idle),
		.compress_en(compress_s),
		.in_word(mem_word),
		.in_pop(dec_pop),
		.take(load_out),
		.out_byte(dec_byte),
		.out_valid(dec_valid)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Pin drivers

	assign SERIAL_OUT_BIT = shift_reg[7];
	assign PARALLEL_OUT_BYTE = byte_reg;
	// Serial pin floats unless both enables are asserted in serial mode
	assign SERIAL_OUT_OE_N = ~(enabled & ~parallel_s);
	// Byte pins driven only with busy low, request released and enables on
	assign PARALLEL_OUT_OE_N = ~(enabled & parallel_s & released & ~busy_s);

	////////////////////////////////////////////////////////////////////////////////
	// Status back to the system domain

	// Streaming level synchronised onto the system clock
	logic act_meta_reg;
	logic act_reg;

	// Two-flop crossing of the run level
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			act_meta_reg <= 1'b0;
			act_reg <= 1'b0;
		end else begin
			act_meta_reg <= state_reg[2];
			act_reg <= act_meta_reg;
		end
	end

	assign STREAM_ACTIVE = act_reg;

endmodule // config_prom_bitstream_output

`default_nettype wire

// >>> sim/config_prom_bitstream_output_chk.sv
// Port assertions for the configuration output stage
`timescale 1ns/10ps
`default_nettype none

module cfg_out_chk #(
	parameter int REV_W = 2
) (
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic CONFIG_CLOCK,
	input wire logic RECONFIG_REQUEST_N,
	input wire logic CHIP_ENABLE_N,
	input wire logic OUTPUT_ENABLE_N,
	input wire logic BUSY,
	input wire logic PARALLEL_MODE,
	input wire logic CLOCK_SOURCE_EN,
	input wire logic START_CONFIG,
	input wire logic REV_WR,
	input wire logic [REV_W-1:0] REV_WR_VALUE,
	input wire logic SERIAL_OUT_OE_N,
	input wire logic [7:0] PARALLEL_OUT_BYTE,
	input wire logic PARALLEL_OUT_OE_N,
	input wire logic CONFIG_CLOCK_OUT,
	input wire logic CONFIG_CLOCK_OUT_OE_N,
	input wire logic PROGRAM_N_OUT,
	input wire logic PROGRAM_N_OE_N,
	input wire logic STREAM_ACTIVE,
	input wire logic [REV_W-1:0] REV_INTERNAL
);
	logic [7:0] low_cnt_reg; // Cycles spent in the program pulse
	// Counts the program pulse, cleared while the pin floats
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST)
			low_cnt_reg <= 8'h00;
		else
			low_cnt_reg <= PROGRAM_N_OE_N ? 8'h00 : low_cnt_reg + 8'h01;
	end
	// Link samples with the stream held off
	sequence s_disabled;
		(CHIP_ENABLE_N || OUTPUT_ENABLE_N) [*4];
	endsequence
	// Link samples with byte output paused
	sequence s_byte_held;
		(BUSY && RECONFIG_REQUEST_N && PARALLEL_MODE) [*5];
	endsequence
	////////////////////////////////////////////////////////////
	a_clk_oe_follow: assert property (@(posedge SYS_CLK) disable iff (RST)
		CONFIG_CLOCK_OUT_OE_N == !CLOCK_SOURCE_EN) else $error("clock drive wrong");
	a_clk_high_width: assert property (@(posedge SYS_CLK) disable iff (RST)
		$rose(CONFIG_CLOCK_OUT) |-> CONFIG_CLOCK_OUT [*4]) else $error("clock high short");
	a_prog_start: assert property (@(posedge SYS_CLK) disable iff (RST)
		START_CONFIG && PROGRAM_N_OE_N && !STREAM_ACTIVE |=> !PROGRAM_N_OE_N)
		else $error("program pulse not started");
	a_prog_length: assert property (@(posedge SYS_CLK) disable iff (RST)
		$rose(PROGRAM_N_OE_N) |-> low_cnt_reg == 8'h7d) else $error("program pulse length");
	a_prog_pin_low: assert property (@(posedge SYS_CLK) disable iff (RST)
		PROGRAM_N_OUT == 1'b0) else $error("program pin level");
	a_rev_write: assert property (@(posedge SYS_CLK) disable iff (RST)
		REV_WR |=> REV_INTERNAL == $past(REV_WR_VALUE)) else $error("revision not written");
	a_rev_hold: assert property (@(posedge SYS_CLK) disable iff (RST)
		!REV_WR |=> $stable(REV_INTERNAL)) else $error("revision changed");
	a_float_disabled: assert property (@(posedge CONFIG_CLOCK) disable iff (RST)
		s_disabled |-> SERIAL_OUT_OE_N && PARALLEL_OUT_OE_N) else $error("driven while off");
	a_byte_gate: assert property (@(posedge CONFIG_CLOCK) disable iff (RST)
		(BUSY || !RECONFIG_REQUEST_N) [*4] |-> PARALLEL_OUT_OE_N) else $error("bytes driven");
	a_busy_hold: assert property (@(posedge CONFIG_CLOCK) disable iff (RST)
		s_byte_held |=> $stable(PARALLEL_OUT_BYTE)) else $error("byte moved while paused");
endmodule // cfg_out_chk

bind config_prom_bitstream_output cfg_out_chk #(.REV_W(REV_W)) u_cfg_out_chk (
	.SYS_CLK(SYS_CLK), .RST(RST), .CONFIG_CLOCK(CONFIG_CLOCK),
	.RECONFIG_REQUEST_N(RECONFIG_REQUEST_N), .CHIP_ENABLE_N(CHIP_ENABLE_N),
	.OUTPUT_ENABLE_N(OUTPUT_ENABLE_N), .BUSY(BUSY), .PARALLEL_MODE(PARALLEL_MODE),
	.CLOCK_SOURCE_EN(CLOCK_SOURCE_EN), .START_CONFIG(START_CONFIG), .REV_WR(REV_WR),
	.REV_WR_VALUE(REV_WR_VALUE), .SERIAL_OUT_OE_N(SERIAL_OUT_OE_N),
	.PARALLEL_OUT_BYTE(PARALLEL_OUT_BYTE), .PARALLEL_OUT_OE_N(PARALLEL_OUT_OE_N),
	.CONFIG_CLOCK_OUT(CONFIG_CLOCK_OUT), .CONFIG_CLOCK_OUT_OE_N(CONFIG_CLOCK_OUT_OE_N),
	.PROGRAM_N_OUT(PROGRAM_N_OUT), .PROGRAM_N_OE_N(PROGRAM_N_OE_N),
	.STREAM_ACTIVE(STREAM_ACTIVE), .REV_INTERNAL(REV_INTERNAL));
`default_nettype wire

// >>> sim/cfg_device_model.sv
// Programmable device side: makes the link clock and busy, captures the stream
`timescale 1ns/10ps
`default_nettype none

module cfg_device_model (
	output logic link_clk,
	output logic busy,
	input wire logic par_mode,
	input wire logic ser_bit,
	input wire logic ser_oe_n,
	input wire logic [7:0] byte_in,
	input wire logic byte_oe_n
);
	logic [7:0] got[$]; // Bytes captured in this frame
	logic [7:0] sh; // Serial assembly, first bit ends up on top
	int edges; // Link edges given in this frame
	int bits; // Serial bits taken
	bit cap; // Capture wanted
	initial begin
		link_clk = 1'b0;
		busy = 1'b0;
		cap = 1'b0;
	end
	// Takes each unit on the edge after launch, past the start-up edges
	always @(posedge link_clk) begin
		edges++;
		if (cap && edges > 5 && !(par_mode ? byte_oe_n : ser_oe_n)) begin
			sh = {sh[6:0], ser_bit};
			bits++;
			if (par_mode)
				got.push_back(byte_in);
			else if (bits % 8 == 0)
				got.push_back(sh);
		end
	end
	// One frame; the clock stands still between frames
	task automatic run(input bit c, input int n, input bit stall);
		cap = c;
		got.delete();
		edges = 0;
		bits = 0;
		#7.3;
		while (edges < 300 && (c ? got.size() < n : edges < n)) begin
			link_clk = 1'b1;
			#1;
			// Pause in mid-frame while the clock keeps running
			busy = stall && edges > 6 && edges < 12;
			#23;
			link_clk = 1'b0;
			#24;
		end
		busy = 1'b0;
		cap = 1'b0;
	endtask
endmodule // cfg_device_model
`default_nettype wire

// >>> sim/config_prom_bitstream_output_tb.sv
// Self-checking bench for the configuration output stage
`timescale 1ns/10ps
`default_nettype none

module config_prom_bitstream_output_tb;
	logic SYS_CLK = 1'b0, RST, RECONFIG_REQUEST_N = 1'b0, CHIP_ENABLE_N = 1'b1;
	logic OUTPUT_ENABLE_N = 1'b0, PARALLEL_MODE = 1'b0, COMPRESS_EN = 1'b0, REV_WR = 1'b0;
	logic REV_SOURCE_INTERNAL = 1'b0, CLOCK_SOURCE_EN = 1'b0, START_CONFIG = 1'b0;
	logic [1:0] REV_SEL = 2'h0, REV_WR_VALUE = 2'h0, REV_INTERNAL;
	logic PROG_WR_EN = 1'b0, CONFIG_CLOCK, BUSY, SERIAL_OUT_BIT, SERIAL_OUT_OE_N;
	logic [9:0] PROG_WR_ADDR = 10'h000;
	logic [15:0] PROG_WR_DATA = 16'h0000;
	logic [7:0] PARALLEL_OUT_BYTE;
	logic PARALLEL_OUT_OE_N, CONFIG_CLOCK_OUT, CONFIG_CLOCK_OUT_OE_N, PROGRAM_N_OUT;
	logic PROGRAM_N_OE_N, STREAM_ACTIVE;
	int errors = 0, comparisons = 0;
	always #2 SYS_CLK = ~SYS_CLK;
	config_prom_bitstream_output u_config_prom_bitstream_output (
		.SYS_CLK(SYS_CLK), .RST(RST), .CONFIG_CLOCK(CONFIG_CLOCK),
		.RECONFIG_REQUEST_N(RECONFIG_REQUEST_N), .CHIP_ENABLE_N(CHIP_ENABLE_N),
		.OUTPUT_ENABLE_N(OUTPUT_ENABLE_N), .BUSY(BUSY), .PARALLEL_MODE(PARALLEL_MODE),
		.COMPRESS_EN(COMPRESS_EN), .REV_SEL(REV_SEL), .REV_WR(REV_WR),
		.REV_SOURCE_INTERNAL(REV_SOURCE_INTERNAL), .REV_WR_VALUE(REV_WR_VALUE),
		.CLOCK_SOURCE_EN(CLOCK_SOURCE_EN), .START_CONFIG(START_CONFIG),
		.PROG_WR_EN(PROG_WR_EN), .PROG_WR_ADDR(PROG_WR_ADDR), .PROG_WR_DATA(PROG_WR_DATA),
		.SERIAL_OUT_BIT(SERIAL_OUT_BIT), .SERIAL_OUT_OE_N(SERIAL_OUT_OE_N),
		.PARALLEL_OUT_BYTE(PARALLEL_OUT_BYTE), .PARALLEL_OUT_OE_N(PARALLEL_OUT_OE_N),
		.CONFIG_CLOCK_OUT(CONFIG_CLOCK_OUT), .CONFIG_CLOCK_OUT_OE_N(CONFIG_CLOCK_OUT_OE_N),
		.PROGRAM_N_OUT(PROGRAM_N_OUT), .PROGRAM_N_OE_N(PROGRAM_N_OE_N),
		.STREAM_ACTIVE(STREAM_ACTIVE), .REV_INTERNAL(REV_INTERNAL));
	cfg_device_model u_cfg_device_model (
		.link_clk(CONFIG_CLOCK), .busy(BUSY), .par_mode(PARALLEL_MODE),
		.ser_bit(SERIAL_OUT_BIT), .ser_oe_n(SERIAL_OUT_OE_N),
		.byte_in(PARALLEL_OUT_BYTE), .byte_oe_n(PARALLEL_OUT_OE_N));
	////////////////////////////////////////////////////////////
	// Compares and reports a mismatch
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Prints the counts and the verdict
	task automatic results;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Restarts the stream, then lets the device take n bytes
	task automatic frame(input bit par, comp, stall, input int n, input logic [39:0] exp);
		PARALLEL_MODE <= par;
		COMPRESS_EN <= comp;
		RECONFIG_REQUEST_N <= 1'b0;
		CHIP_ENABLE_N <= 1'b1;
		@(posedge SYS_CLK);
		u_cfg_device_model.run(1'b0, 4, 1'b0);
		check(STREAM_ACTIVE, 1'b0);
		@(posedge SYS_CLK);
		RECONFIG_REQUEST_N <= 1'b1;
		CHIP_ENABLE_N <= 1'b0;
		@(posedge SYS_CLK);
		u_cfg_device_model.run(1'b1, n, stall);
		check(16'(u_cfg_device_model.got.size()), 16'(n));
		check(STREAM_ACTIVE, 1'b1);
		for (int i = 0; i < n; i++)
			check(u_cfg_device_model.got[i], exp[8*(n-1-i) +: 8]);
		@(posedge SYS_CLK);
	endtask
	// Revision one: plain, run of three, plain
	task automatic t_load;
		PROG_WR_EN <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			PROG_WR_ADDR <= 10'h100 + 10'(i);
			PROG_WR_DATA <= i == 0 ? 16'h005a : i == 1 ? 16'h8281 : 16'h00c3;
			@(posedge SYS_CLK);
		end
		PROG_WR_EN <= 1'b0;
	endtask
	// Program pulse length, with a second start refused
	task automatic t_program;
		int n;
		START_CONFIG <= 1'b1;
		@(posedge SYS_CLK);
		START_CONFIG <= 1'b0;
		#1 check(PROGRAM_N_OE_N, 1'b0);
		n = 0;
		while (PROGRAM_N_OE_N === 1'b0 && n < 300) begin
			@(posedge SYS_CLK);
			START_CONFIG <= (n == 50);
			n++;
			#1;
		end
		check(16'(n), 16'h007d);
		@(posedge SYS_CLK);
	endtask
	// Internal revision bits written and kept
	task automatic t_rev;
		REV_WR_VALUE <= 2'h1;
		REV_WR <= 1'b1;
		@(posedge SYS_CLK);
		REV_WR <= 1'b0;
		REV_WR_VALUE <= 2'h2;
		#1 check(REV_INTERNAL, 2'h1);
		@(posedge SYS_CLK);
		#1 check(REV_INTERNAL, 2'h1);
		@(posedge SYS_CLK);
	endtask
	// Generated clock: driven, eight rises in 64 cycles
	task automatic t_clock;
		int r;
		logic prev;
		r = 0;
		CLOCK_SOURCE_EN <= 1'b1;
		repeat (8) @(posedge SYS_CLK);
		#1 check(CONFIG_CLOCK_OUT_OE_N, 1'b0);
		prev = CONFIG_CLOCK_OUT;
		repeat (64) begin
			@(posedge SYS_CLK);
			#1 r += (CONFIG_CLOCK_OUT === 1'b1 && prev === 1'b0);
			prev = CONFIG_CLOCK_OUT;
		end
		check(r, 8);
		@(posedge SYS_CLK);
	endtask
	// Serial, revision from the pins, runs not expanded
	task automatic t_serial;
		REV_SEL <= 2'h1;
		frame(1'b0, 1'b0, 1'b0, 3, 40'h5a81c3);
	endtask
	// Byte-wide, internal revision, expanded, with a busy pause
	task automatic t_byte;
		REV_SEL <= 2'h0;
		REV_SOURCE_INTERNAL <= 1'b1;
		frame(1'b1, 1'b1, 1'b1, 5, 40'h5a818181c3);
	endtask
	////////////////////////////////////////////////////////////
	// Main sequence: reset values, then the scenarios
	initial begin
		// Rising reset at time zero, so the link side resets with no link clock running
		RST <= 1'b1;
		@(posedge SYS_CLK);
		#1 check({SERIAL_OUT_OE_N, PARALLEL_OUT_OE_N, CONFIG_CLOCK_OUT, CONFIG_CLOCK_OUT_OE_N,
			PROGRAM_N_OE_N, STREAM_ACTIVE, REV_INTERNAL}, 8'hd8);
		check({PARALLEL_OUT_BYTE, SERIAL_OUT_BIT}, 9'h000);
		@(posedge SYS_CLK);
		RST <= 1'b0;
		@(posedge SYS_CLK);
		t_load;
		t_program;
		t_rev;
		t_clock;
		t_serial;
		t_byte;
		results;
	end
	// Cuts a hang short
	initial begin
		#100000;
		errors++;
		results;
	end
endmodule // config_prom_bitstream_output_tb
`default_nettype wire
